// *** pfsc_pkg.sv ***
package pfsc_pkg;

   // all process values share one signed fixed-point format (8 fraction bits)
   localparam int VAL_W  = 24;
   localparam int FRAC_W = 8;
   localparam int WIDE_W = VAL_W + 2;

   typedef logic signed [VAL_W-1:0]  pfsc_val_t;
   typedef logic signed [WIDE_W-1:0] pfsc_wide_t;

   // wishbone map, byte addresses
   localparam logic [7:0] ADR_CTRL      = 8'h00;
   localparam logic [7:0] ADR_BUS_FB1   = 8'h04;
   localparam logic [7:0] ADR_BUS_FB2   = 8'h08;
   localparam logic [7:0] ADR_SETPT1    = 8'h0C;
   localparam logic [7:0] ADR_SETPT2    = 8'h10;
   localparam logic [7:0] ADR_REF_MIN   = 8'h14;
   localparam logic [7:0] ADR_REF_MAX   = 8'h18;
   localparam logic [7:0] ADR_FEEDBACK  = 8'h1C;
   localparam logic [7:0] ADR_RESULT    = 8'h20;
   localparam logic [7:0] ADR_DEVIATION = 8'h24;
   localparam logic [7:0] ADR_STATUS    = 8'h28;

   // control register fields
   localparam int CTRL_COMB_LSB  = 0;
   localparam int CTRL_COMB_W    = 4;
   localparam int CTRL_SHAPE_BIT = 4;
   localparam int CTRL_DIR_BIT   = 5;
   localparam int CTRL_CLAMP_BIT = 6;
   localparam int CTRL_LOOP_BIT  = 7;

   // status fields
   localparam int STAT_ZONE_BIT  = 0;
   localparam int STAT_HOLD_BIT  = 1;
   localparam int STAT_PRESET_BIT = 2;

   typedef enum logic [3:0] {
      COMB_MIN       = 4'h0,
      COMB_MAX       = 4'h1,
      COMB_SUM       = 4'h2,
      COMB_DIFF      = 4'h3,
      COMB_AVG       = 4'h4,
      COMB_ZONE_HIGH = 4'h5,
      COMB_ZONE_LOW  = 4'h6,
      COMB_FB1_ONLY  = 4'h7,
      COMB_FB2_ONLY  = 4'h8
   } pfsc_comb_e;

   typedef enum logic [1:0] {
      SQRT_IDLE = 2'b00,
      SQRT_RUN  = 2'b01
   } pfsc_sqrt_e;

   localparam logic [3:0]  COMB_RESET   = 4'h1;
   localparam logic        SHAPE_RESET  = 1'b0;
   localparam logic        DIR_RESET    = 1'b0;
   localparam logic        CLAMP_RESET  = 1'b1;
   localparam logic        LOOP_RESET   = 1'b0;
   localparam logic [VAL_W-1:0] VAL_ZERO = 24'h000000;
   localparam logic [VAL_W-1:0] REF_MIN_RESET = 24'h800000;
   localparam logic [VAL_W-1:0] REF_MAX_RESET = 24'h7FFFFF;
   localparam int SQRT_STEPS = VAL_W / 2 + FRAC_W / 2;
   localparam int RAD_W      = 2 * SQRT_STEPS;

   typedef struct packed {
      logic [3:0] comb;
      logic       shape;
      logic       direction;
      logic       clamp_en;
      logic       closed_loop;
   } pfsc_cfg_s;

   typedef struct packed {
      pfsc_sqrt_e              st;
      logic [RAD_W-1:0]        rad;
      logic [SQRT_STEPS+1:0]   rem;
      logic [SQRT_STEPS-1:0]   root;
      logic [4:0]              step;
      logic                    sign;
      pfsc_val_t               result;
   } pfsc_sqrt_s;

   typedef struct packed {
      logic                    ack;
      logic [31:0]             dat;
      pfsc_cfg_s               cfg;
      pfsc_val_t               bus_fb1;
      pfsc_val_t               bus_fb2;
      pfsc_val_t               setpt1;
      pfsc_val_t               setpt2;
      pfsc_val_t               ref_min;
      pfsc_val_t               ref_max;
      pfsc_val_t               fb1;
      pfsc_val_t               fb2;
      pfsc_val_t               feedback;
      pfsc_val_t               result_ref;
      pfsc_val_t               deviation;
      logic                    zone2;
      logic                    hold;
      logic                    preset;
      logic                    direction;
      logic                    clamp_en;
      pfsc_sqrt_s              sq1;
      pfsc_sqrt_s              sq2;
   } pfsc_state_s;

endpackage

// *** pfsc_combiner.sv ***
// Notes on behaviour
// - feedback one is bus value one plus scaled first voltage input
// - feedback two is bus value two plus scaled second voltage input
// - shaping code 0 passes feedback, code 1 takes square root; default 0
// - feedback path runs in open and closed loop for display
// - single feedback compares remote reference plus setpoint one (setpoint two in code 8) with feedback
// - combine code 0 regulates on the lower feedback
// - combine code 1, default, regulates on the higher feedback
// - combine code 2 regulates on the sum, setpoint one added
// - combine code 3 regulates on feedback two minus feedback one
// - combine code 4 regulates on the mean, setpoint one added
// - combine code 5 picks the larger signed zone difference
// - in code 5 the winning zone's setpoint joins the remote reference
// - combine code 6 picks the smaller signed zone difference
// - in code 6 the winning zone's setpoint joins the remote reference
// - combine code 7 uses only input one against setpoint one
// - combine code 8 uses only input two against setpoint two
// - setpoint two, default zero, acts in closed loop two-zone modes and in code 8
// - direction code 0 lowers frequency on rising feedback, code 1 raises
// - anti-windup code 0 disables, code 1 (default) enables
// - at a limit with anti-windup in closed loop, preset integrator and hold until deviation crosses zero
//
// Design decisions made here: register access over Wishbone and the register offsets.
module pfsc_combiner (
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [31:0]       wb_dat_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic              wb_we_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   output logic                   wb_ack_o,
   output logic [31:0]            wb_dat_o,
   input  wire pfsc_pkg::pfsc_val_t volt_in1_i,
   input  wire pfsc_pkg::pfsc_val_t volt_in2_i,
   input  wire pfsc_pkg::pfsc_val_t remote_ref_i,
   input  wire logic              limit_reached_i,
   output pfsc_pkg::pfsc_val_t    feedback_o,
   output pfsc_pkg::pfsc_val_t    result_ref_o,
   output pfsc_pkg::pfsc_val_t    deviation_o,
   output logic                   direction_inverse_o,
   output logic                   integrator_clamp_o,
   output logic                   integrator_preset_o,
   output logic                   regulation_hold_o
);

   pfsc_pkg::pfsc_state_s  s;
   pfsc_pkg::pfsc_state_s  next_s;

   // one sequential square root per channel; restoring method, one bit per cycle
   function automatic pfsc_pkg::pfsc_sqrt_s sqrt_step(input pfsc_pkg::pfsc_sqrt_s q,
                                                       input pfsc_pkg::pfsc_val_t x);
      pfsc_pkg::pfsc_sqrt_s     n;
      logic [pfsc_pkg::SQRT_STEPS+1:0] trial;
      logic [pfsc_pkg::SQRT_STEPS+1:0] cand;
      n = q;
      trial = '0;
      cand = '0;
      case (q.st)
         pfsc_pkg::SQRT_IDLE: begin
            // negative input is taken by magnitude, sign restored on the result
            n.sign = x[pfsc_pkg::VAL_W-1];
            n.rad = {(x[pfsc_pkg::VAL_W-1] ? -x : x), {pfsc_pkg::FRAC_W{1'b0}}};
            n.rem = '0;
            n.root = '0;
            n.step = '0;
            n.st = pfsc_pkg::SQRT_RUN;
         end
         pfsc_pkg::SQRT_RUN: begin
            trial = {q.rem[pfsc_pkg::SQRT_STEPS-1:0], q.rad[pfsc_pkg::RAD_W-1 -: 2]};
            cand = {q.root, 2'b01};
            n.rad = {q.rad[pfsc_pkg::RAD_W-3:0], 2'b00};
            if (trial >= cand) begin
               n.rem = trial - cand;
               n.root = {q.root[pfsc_pkg::SQRT_STEPS-2:0], 1'b1};
            end else begin
               n.rem = trial;
               n.root = {q.root[pfsc_pkg::SQRT_STEPS-2:0], 1'b0};
            end
            n.step = q.step + 5'h01;
            if (q.step == 5'(pfsc_pkg::SQRT_STEPS - 1)) begin
               n.result = pfsc_pkg::pfsc_val_t'({1'b0, n.root[pfsc_pkg::SQRT_STEPS-1:0]});
               if (q.sign)
                  n.result = -n.result;
               n.st = pfsc_pkg::SQRT_IDLE;
            end
         end
         default: begin
            n.st = pfsc_pkg::SQRT_IDLE;
         end
      endcase
      return n;
   endfunction

   function automatic pfsc_pkg::pfsc_val_t sat(input pfsc_pkg::pfsc_wide_t w);
      if (w > pfsc_pkg::pfsc_wide_t'($signed(pfsc_pkg::REF_MAX_RESET)))
         sat = pfsc_pkg::REF_MAX_RESET;
      else if (w < pfsc_pkg::pfsc_wide_t'($signed(pfsc_pkg::REF_MIN_RESET)))
         sat = pfsc_pkg::REF_MIN_RESET;
      else
         sat = w[pfsc_pkg::VAL_W-1:0];
   endfunction

   function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
      wb_merge = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i])
            wb_merge[8*i +: 8] = d[8*i +: 8];
      end
   endfunction

   function automatic logic [31:0] sx(input pfsc_pkg::pfsc_val_t v);
      sx = 32'($signed(v));
   endfunction

   pfsc_pkg::pfsc_wide_t  raw1;
   pfsc_pkg::pfsc_wide_t  raw2;
   pfsc_pkg::pfsc_val_t   ch1;
   pfsc_pkg::pfsc_val_t   ch2;
   pfsc_pkg::pfsc_val_t   fb_sel;
   pfsc_pkg::pfsc_val_t   sp_sel;
   pfsc_pkg::pfsc_wide_t  d1;
   pfsc_pkg::pfsc_wide_t  d2;
   pfsc_pkg::pfsc_wide_t  wide;
   pfsc_pkg::pfsc_wide_t  dev_w;
   pfsc_pkg::pfsc_val_t   new_dev;
   pfsc_pkg::pfsc_val_t   sp2_eff;
   logic                  zone_mode;
   logic                  pick2;
   logic                  wr;
   logic [31:0]           cur;

   always_comb begin
      next_s = s;
      raw1 = '0;
      raw2 = '0;
      ch1 = '0;
      ch2 = '0;
      fb_sel = '0;
      sp_sel = '0;
      d1 = '0;
      d2 = '0;
      wide = '0;
      dev_w = '0;
      new_dev = '0;
      pick2 = 1'b0;
      cur = '0;

      // channel sums run regardless of loop mode so open loop can display them
      raw1 = pfsc_pkg::pfsc_wide_t'(s.bus_fb1) + pfsc_pkg::pfsc_wide_t'(volt_in1_i);
      raw2 = pfsc_pkg::pfsc_wide_t'(s.bus_fb2) + pfsc_pkg::pfsc_wide_t'(volt_in2_i);
      next_s.fb1 = sat(raw1);
      next_s.fb2 = sat(raw2);
      next_s.sq1 = sqrt_step(s.sq1, s.fb1);
      next_s.sq2 = sqrt_step(s.sq2, s.fb2);
      ch1 = s.cfg.shape ? s.sq1.result : s.fb1;
      ch2 = s.cfg.shape ? s.sq2.result : s.fb2;

      zone_mode = (s.cfg.comb == pfsc_pkg::COMB_ZONE_HIGH) || (s.cfg.comb == pfsc_pkg::COMB_ZONE_LOW);
      // in the two-zone modes setpoint two is only honoured in closed loop
      sp2_eff = (s.cfg.closed_loop && zone_mode) ? s.setpt2 : pfsc_pkg::VAL_ZERO;
      d1 = pfsc_pkg::pfsc_wide_t'(s.setpt1) - pfsc_pkg::pfsc_wide_t'(ch1);
      d2 = pfsc_pkg::pfsc_wide_t'(sp2_eff) - pfsc_pkg::pfsc_wide_t'(ch2);

      sp_sel = s.setpt1;
      case (s.cfg.comb)
         pfsc_pkg::COMB_MIN: fb_sel = (ch1 < ch2) ? ch1 : ch2;
         pfsc_pkg::COMB_MAX: fb_sel = (ch1 > ch2) ? ch1 : ch2;
         pfsc_pkg::COMB_SUM: begin
            wide = pfsc_pkg::pfsc_wide_t'(ch1) + pfsc_pkg::pfsc_wide_t'(ch2);
            fb_sel = sat(wide);
         end
         pfsc_pkg::COMB_DIFF: begin
            wide = pfsc_pkg::pfsc_wide_t'(ch2) - pfsc_pkg::pfsc_wide_t'(ch1);
            fb_sel = sat(wide);
         end
         pfsc_pkg::COMB_AVG: begin
            wide = (pfsc_pkg::pfsc_wide_t'(ch1) + pfsc_pkg::pfsc_wide_t'(ch2)) >>> 1;
            fb_sel = wide[pfsc_pkg::VAL_W-1:0];
         end
         pfsc_pkg::COMB_ZONE_HIGH: begin
            pick2 = d2 > d1;
            fb_sel = pick2 ? ch2 : ch1;
            sp_sel = pick2 ? sp2_eff : s.setpt1;
         end
         pfsc_pkg::COMB_ZONE_LOW: begin
            pick2 = d2 < d1;
            fb_sel = pick2 ? ch2 : ch1;
            sp_sel = pick2 ? sp2_eff : s.setpt1;
         end
         pfsc_pkg::COMB_FB1_ONLY: fb_sel = ch1;
         pfsc_pkg::COMB_FB2_ONLY: begin
            // second setpoint is taken directly here, unlike the zone modes
            fb_sel = ch2;
            sp_sel = s.setpt2;
         end
         default: fb_sel = (ch1 > ch2) ? ch1 : ch2;
      endcase

      next_s.feedback = fb_sel;
      next_s.zone2 = pick2;
      next_s.result_ref = sat(pfsc_pkg::pfsc_wide_t'(remote_ref_i) + pfsc_pkg::pfsc_wide_t'(sp_sel));
      if ($signed(next_s.result_ref) > $signed(s.ref_max))
         next_s.result_ref = s.ref_max;
      else if ($signed(next_s.result_ref) < $signed(s.ref_min))
         next_s.result_ref = s.ref_min;
      dev_w = pfsc_pkg::pfsc_wide_t'(s.result_ref) - pfsc_pkg::pfsc_wide_t'(s.feedback);
      new_dev = sat(dev_w);
      next_s.deviation = new_dev;
      next_s.direction = s.cfg.direction;
      next_s.clamp_en = s.cfg.clamp_en;

      // anti-windup: preset pulse on entering a limit, hold until the limit is gone and deviation is zero or flips sign
      next_s.preset = 1'b0;
      if (!s.cfg.clamp_en || !s.cfg.closed_loop) begin
         next_s.hold = 1'b0;
      end else if (limit_reached_i && !s.hold) begin
         next_s.hold = 1'b1;
         next_s.preset = 1'b1;
      end else if (s.hold && !limit_reached_i &&
                   (new_dev == pfsc_pkg::VAL_ZERO || new_dev[pfsc_pkg::VAL_W-1] != s.deviation[pfsc_pkg::VAL_W-1])) begin
         next_s.hold = 1'b0;
      end

      // wishbone classic slave: one registered ack per request, raised the cycle after it and dropped the next cycle
      wr = 1'b0;
      next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
      if (wb_cyc_i && wb_stb_i && !s.ack) begin
         wr = wb_we_i;
         case (wb_adr_i)
            pfsc_pkg::ADR_CTRL: cur = {24'h000000, s.cfg.closed_loop, s.cfg.clamp_en, s.cfg.direction,
                                       s.cfg.shape, s.cfg.comb};
            pfsc_pkg::ADR_BUS_FB1:   cur = sx(s.bus_fb1);
            pfsc_pkg::ADR_BUS_FB2:   cur = sx(s.bus_fb2);
            pfsc_pkg::ADR_SETPT1:    cur = sx(s.setpt1);
            pfsc_pkg::ADR_SETPT2:    cur = sx(s.setpt2);
            pfsc_pkg::ADR_REF_MIN:   cur = sx(s.ref_min);
            pfsc_pkg::ADR_REF_MAX:   cur = sx(s.ref_max);
            pfsc_pkg::ADR_FEEDBACK:  cur = sx(s.feedback);
            pfsc_pkg::ADR_RESULT:    cur = sx(s.result_ref);
            pfsc_pkg::ADR_DEVIATION: cur = sx(s.deviation);
            pfsc_pkg::ADR_STATUS:    cur = {29'h00000000, s.preset, s.hold, s.zone2};
            default:                 cur = 32'h00000000;
         endcase
         next_s.dat = wr ? 32'h00000000 : cur;
         if (wr) begin
            cur = wb_merge(cur, wb_dat_i, wb_sel_i);
            case (wb_adr_i)
               pfsc_pkg::ADR_CTRL: begin
                  // combine codes above the last mode are refused and keep the old value
                  if (cur[pfsc_pkg::CTRL_COMB_LSB +: pfsc_pkg::CTRL_COMB_W] <= pfsc_pkg::COMB_FB2_ONLY)
                     next_s.cfg.comb = cur[pfsc_pkg::CTRL_COMB_LSB +: pfsc_pkg::CTRL_COMB_W];
                  next_s.cfg.shape = cur[pfsc_pkg::CTRL_SHAPE_BIT];
                  next_s.cfg.direction = cur[pfsc_pkg::CTRL_DIR_BIT];
                  next_s.cfg.clamp_en = cur[pfsc_pkg::CTRL_CLAMP_BIT];
                  next_s.cfg.closed_loop = cur[pfsc_pkg::CTRL_LOOP_BIT];
               end
               pfsc_pkg::ADR_BUS_FB1: next_s.bus_fb1 = cur[pfsc_pkg::VAL_W-1:0];
               pfsc_pkg::ADR_BUS_FB2: next_s.bus_fb2 = cur[pfsc_pkg::VAL_W-1:0];
               pfsc_pkg::ADR_SETPT1:  next_s.setpt1 = cur[pfsc_pkg::VAL_W-1:0];
               pfsc_pkg::ADR_SETPT2:  next_s.setpt2 = cur[pfsc_pkg::VAL_W-1:0];
               pfsc_pkg::ADR_REF_MIN: next_s.ref_min = cur[pfsc_pkg::VAL_W-1:0];
               pfsc_pkg::ADR_REF_MAX: next_s.ref_max = cur[pfsc_pkg::VAL_W-1:0];
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         s <= '0;
         s.cfg.comb <= pfsc_pkg::COMB_RESET;
         s.cfg.shape <= pfsc_pkg::SHAPE_RESET;
         s.cfg.direction <= pfsc_pkg::DIR_RESET;
         s.cfg.clamp_en <= pfsc_pkg::CLAMP_RESET;
         s.cfg.closed_loop <= pfsc_pkg::LOOP_RESET;
         s.clamp_en <= pfsc_pkg::CLAMP_RESET;
         s.ref_min <= pfsc_pkg::REF_MIN_RESET;
         s.ref_max <= pfsc_pkg::REF_MAX_RESET;
         s.sq1.st <= pfsc_pkg::SQRT_IDLE;
         s.sq2.st <= pfsc_pkg::SQRT_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign wb_ack_o = s.ack;
   assign wb_dat_o = s.dat;
   assign feedback_o = s.feedback;
   assign result_ref_o = s.result_ref;
   assign deviation_o = s.deviation;
   assign direction_inverse_o = s.direction;
   assign integrator_clamp_o = s.clamp_en;
   assign integrator_preset_o = s.preset;
   assign regulation_hold_o = s.hold;

endmodule

// *** pfsc_combiner_monitor.sv ***
module pfsc_combiner_monitor (
   input wire logic                clock_i,
   input wire logic                rst_i,
   input wire logic [7:0]          wb_adr_i,
   input wire logic [31:0]         wb_dat_i,
   input wire logic                wb_we_i,
   input wire logic                wb_cyc_i,
   input wire logic                wb_stb_i,
   input wire logic                wb_ack_o,
   input wire logic [31:0]         wb_dat_o,
   input wire logic                limit_reached_i,
   input wire pfsc_pkg::pfsc_val_t feedback_o,
   input wire pfsc_pkg::pfsc_val_t result_ref_o,
   input wire pfsc_pkg::pfsc_val_t deviation_o,
   input wire logic                direction_inverse_o,
   input wire logic                integrator_clamp_o,
   input wire logic                integrator_preset_o,
   input wire logic                regulation_hold_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // widened so that the reference difference cannot wrap before it is compared
   pfsc_pkg::pfsc_wide_t dev_q;
   logic                 ctrl_wr;
   assign ctrl_wr = wb_ack_o && wb_we_i && wb_adr_i == pfsc_pkg::ADR_CTRL;
   always_ff @(posedge clock_i) begin
      dev_q <= pfsc_pkg::pfsc_wide_t'(result_ref_o) - pfsc_pkg::pfsc_wide_t'(feedback_o);
   end
   default clocking mon_cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered in the next cycle");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus answer stands longer than one cycle");
   AST_WACK_ZERO: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h00000000)
      else $error("write answer carries data");
   AST_DIR_COPY: assert property (ctrl_wr |=> direction_inverse_o == $past(wb_dat_i[5]))
      else $error("direction output does not follow control write");
   AST_CLAMP_COPY: assert property (ctrl_wr |=> integrator_clamp_o == $past(wb_dat_i[6]))
      else $error("anti windup output does not follow control write");
   // only compared where the true difference fits the value format
   AST_DEVIATION: assert property (dev_q[25:23] == 3'b000 || dev_q[25:23] == 3'b111 |->
      deviation_o == dev_q[23:0])
      else $error("deviation is not reference minus feedback");
   AST_PRESET_ONE: assert property (integrator_preset_o |=> !integrator_preset_o)
      else $error("integrator preset longer than one cycle");
   AST_PRESET_CAUSE: assert property (integrator_preset_o |-> regulation_hold_o && $past(limit_reached_i))
      else $error("integrator preset without limit or hold");
   AST_HOLD_OFF: assert property (!integrator_clamp_o |-> !regulation_hold_o)
      else $error("regulation held with anti windup disabled");
   COV_PRESET: cover property (integrator_preset_o);
   COV_WRITE: cover property (wb_ack_o && wb_we_i);
   COV_RELEASE: cover property (regulation_hold_o ##1 !regulation_hold_o);
   COV_NEG_DEV: cover property (deviation_o < 0);
endmodule

// *** pfsc_transmitter_model.sv ***
module pfsc_transmitter_model (
   input  wire logic                clock_i,
   input  wire pfsc_pkg::pfsc_val_t level1_i,
   input  wire pfsc_pkg::pfsc_val_t level2_i,
   output pfsc_pkg::pfsc_val_t      volt1_o,
   output pfsc_pkg::pfsc_val_t      volt2_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // both process values come in on the voltage inputs, two-zone use included
   always_ff @(posedge clock_i) begin
      volt1_o <= level1_i;
      volt2_o <= level2_i;
   end
endmodule

// *** pfsc_combiner_test.sv ***
module pfsc_combiner_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clock_i = 1'b0;
   logic                rst_i = 1'b1;
   logic [7:0]          adr = 8'h00;
   logic [31:0]         wdat = 32'h00000000;
   logic [31:0]         rdat, dat_o;
   logic [3:0]          sel = 4'h0;
   logic                we = 1'b0, cyc = 1'b0, stb = 1'b0, lim = 1'b0;
   logic                ack, dir_o, clamp_o, preset_o, hold_o;
   pfsc_pkg::pfsc_val_t lv1 = 24'h000000, lv2 = 24'h000000, rr = 24'h000000;
   pfsc_pkg::pfsc_val_t v1, v2, fb_o, ref_o, dev_o;
   int                  n_errors = 0, n_compared = 0;
   pfsc_pkg::pfsc_val_t exp_fb [9] = '{24'h000280, 24'h000400, 24'h000680, 24'hFFFE80, 24'h000340,
                                       24'h000400, 24'h000280, 24'h000400, 24'h000280};
   pfsc_pkg::pfsc_val_t exp_ref [9] = '{24'h000600, 24'h000600, 24'h000600, 24'h000600, 24'h000600,
                                        24'h000600, 24'h000180, 24'h000600, 24'h000180};

   always #5 clock_i = ~clock_i;

   pfsc_transmitter_model xmtr (.clock_i(clock_i), .level1_i(lv1), .level2_i(lv2), .volt1_o(v1), .volt2_o(v2));

   pfsc_combiner DUT (.clock_i(clock_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .wb_dat_o(dat_o), .volt_in1_i(v1),
      .volt_in2_i(v2), .remote_ref_i(rr), .limit_reached_i(lim), .feedback_o(fb_o), .result_ref_o(ref_o),
      .deviation_o(dev_o), .direction_inverse_o(dir_o), .integrator_clamp_o(clamp_o),
      .integrator_preset_o(preset_o), .regulation_hold_o(hold_o));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do begin
         @(posedge clock_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rdat = dat_o;
      if (n >= 20) n_errors++;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      check(name, rdat, e);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   task automatic end_of_test;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clock_i);
      rst_i <= 1'b0;
      settle(1);
      check("clamp_o", clamp_o, 32'h00000001);
      check("dir_o", dir_o, 32'h00000000);
      rd_chk("ctrl", pfsc_pkg::ADR_CTRL, 32'h00000041);
      rd_chk("setpt2", pfsc_pkg::ADR_SETPT2, 32'h00000000);
      rd_chk("ref_min", pfsc_pkg::ADR_REF_MIN, 32'hFF800000);
      bus(1'b1, 8'h2C, 32'h12345678);
      rd_chk("unmapped", 8'h2C, 32'h00000000);
      bus(1'b1, pfsc_pkg::ADR_BUS_FB1, 32'h00000100);
      bus(1'b1, pfsc_pkg::ADR_BUS_FB2, 32'h00000200);
      bus(1'b1, pfsc_pkg::ADR_SETPT1, 32'h00000500);
      bus(1'b1, pfsc_pkg::ADR_SETPT2, 32'h00000080);
      @(posedge clock_i);
      lv1 <= 24'h000300;
      lv2 <= 24'h000080;
      rr <= 24'h000100;
      // zone two has the larger magnitude but a negative difference
      for (int m = 0; m < 9; m++) begin
         bus(1'b1, pfsc_pkg::ADR_CTRL, 32'h000000C0 | 32'(m));
         settle(6);
         check("feedback", fb_o, exp_fb[m]);
         check("result_ref", ref_o, exp_ref[m]);
         check("deviation", dev_o, 32'(pfsc_pkg::pfsc_val_t'(exp_ref[m] - exp_fb[m])));
         rd_chk("fb_reg", pfsc_pkg::ADR_FEEDBACK, 32'(exp_fb[m]));
         if (m == 5 || m == 6)
            rd_chk("status", pfsc_pkg::ADR_STATUS, (m == 6) ? 32'h00000001 : 32'h00000000);
      end
      bus(1'b1, pfsc_pkg::ADR_CTRL, 32'h00000046);
      settle(6);
      check("open_fb", fb_o, 32'h00000280);
      check("open_ref", ref_o, 32'h00000100);
      // square root only with a single-feedback mode
      bus(1'b1, pfsc_pkg::ADR_CTRL, 32'h00000057);
      @(posedge clock_i);
      lv1 <= 24'h000F00;
      settle(45);
      check("sqrt_fb", fb_o, 32'h00000400);
      bus(1'b1, pfsc_pkg::ADR_CTRL, 32'h000000C7);
      @(posedge clock_i);
      lv1 <= 24'h000300;
      settle(6);
      check("dev_pos", dev_o, 32'h00000200);
      @(posedge clock_i);
      lim <= 1'b1;
      settle(1);
      check("preset", preset_o, 32'h00000001);
      check("hold", hold_o, 32'h00000001);
      settle(1);
      check("preset_end", preset_o, 32'h00000000);
      @(posedge clock_i);
      lim <= 1'b0;
      settle(4);
      check("hold_kept", hold_o, 32'h00000001);
      @(posedge clock_i);
      lv1 <= 24'h000700;
      settle(8);
      check("dev_neg", dev_o, 32'hFFFFFE00);
      check("hold_free", hold_o, 32'h00000000);
      bus(1'b1, pfsc_pkg::ADR_CTRL, 32'h000000A7);
      settle(2);
      check("clamp_off", clamp_o, 32'h00000000);
      check("dir_inv", dir_o, 32'h00000001);
      @(posedge clock_i);
      lim <= 1'b1;
      settle(3);
      check("no_hold", hold_o, 32'h00000000);
      check("no_preset", preset_o, 32'h00000000);
      end_of_test;
   end

   initial begin
      repeat (20000) @(posedge clock_i);
      n_errors++;
      end_of_test;
   end
endmodule

bind pfsc_combiner pfsc_combiner_monitor mon (.clock_i(clock_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .wb_dat_o(wb_dat_o), .limit_reached_i(limit_reached_i), .feedback_o(feedback_o),
   .result_ref_o(result_ref_o), .deviation_o(deviation_o), .direction_inverse_o(direction_inverse_o),
   .integrator_clamp_o(integrator_clamp_o), .integrator_preset_o(integrator_preset_o),
   .regulation_hold_o(regulation_hold_o));
